// ---- dv/asr_drive_model.sv ----
// behavioural axis drive: setpoint ramps to target, actual follows
`timescale 1ns/1ns
module asr_drive_model #(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic motion_enable,
    input wire logic [POS_W-1:0] target_pos,
    input wire logic stall,
    input wire logic [POS_W-1:0] step,
    output logic [POS_W-1:0] setpoint,
    output logic [POS_W-1:0] actual,
    output logic scan_tick
);
    logic [2:0] tick_cnt;
    // scan strobe every eighth cycle, slow enough to see standstill
    assign scan_tick = (tick_cnt == 3'h7);
    // a stalled load freezes actual, like a drifting power unit would
    always_ff @(posedge clk) begin
        if (rst) begin
            setpoint <= '0;
            actual <= '0;
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 3'h1;
            if (!stall)
                actual <= setpoint;
            if (motion_enable && target_pos > setpoint)
                setpoint <= (target_pos - setpoint > step) ? setpoint + step : target_pos;
            else if (motion_enable && target_pos < setpoint)
                setpoint <= (setpoint - target_pos > step) ? setpoint - step : target_pos;
        end
    end
endmodule

// ---- dv/axis_status_position_reached_tb_top.sv ----
// self-checking bench for the axis status and position-reached block
`timescale 1ns/1ns
module axis_status_position_reached_tb_top;
    import asr_pkg::*;
    typedef struct {logic [3:0] m; logic teach;} asr_row_t;
    logic clk = 0, rst = 1, scan_tick, job_valid = 0, job_stop = 0, job_abort = 0;
    logic cfg_transfer = 0, cfg_error = 0, ref_set = 0, stmt_done = 0, program_done = 0, cpu_ready = 1;
    logic stall = 0, motion_enable, job_accept, operational_ready_output, in_position_output;
    logic [3:0] job_mode = '0;
    logic [1:0] cfg_unit = UNIT_METRIC, job_error;
    logic [7:0] axis_attribute_byte;
    logic [31:0] job_target = '0, setpoint, actual, target_pos, distance_to_go;
    int n_mismatch = 0, n_tests = 0, c;
    asr_row_t rows[3] = '{'{MODE_TEACH_ON, 1'b1}, '{MODE_OTHER, 1'b1}, '{MODE_TEACH_OFF, 1'b0}};
    // short wait count keeps the target-approach timeout simulable
    asr_axis_status #(.WAIT_COUNT(50)) dut_u (.clk(clk), .rst(rst), .scan_tick(scan_tick),
        .job_valid(job_valid), .job_mode(job_mode), .job_stop(job_stop), .job_abort(job_abort),
        .job_target(job_target), .cfg_transfer(cfg_transfer), .cfg_error(cfg_error),
        .cfg_unit(cfg_unit), .ref_set(ref_set), .cpu_ready(cpu_ready), .stmt_done(stmt_done),
        .program_done(program_done), .setpoint(setpoint), .actual(actual),
        .brake_dist(32'h14), .standstill_window(32'h4), .axis_attribute_byte(axis_attribute_byte),
        .job_accept(job_accept), .job_error(job_error), .motion_enable(motion_enable),
        .target_pos(target_pos), .distance_to_go(distance_to_go),
        .operational_ready_output(operational_ready_output), .in_position_output(in_position_output));
    asr_drive_model drive_u (.clk(clk), .rst(rst), .motion_enable(motion_enable),
        .target_pos(target_pos), .stall(stall), .step(32'h7), .setpoint(setpoint),
        .actual(actual), .scan_tick(scan_tick));
    // 250 MHz clock
    always #2 clk = ~clk;
    task automatic give_verdict();
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic job(input logic [3:0] m, input logic [31:0] t);
        job_valid = 1;
        job_mode = m;
        job_target = t;
        tick(1);
        job_valid = 0;
    endtask
    task automatic cfg(input logic e);
        cfg_error = e;
        cfg_unit = UNIT_INCH;
        cfg_transfer = 1;
        tick(1);
        cfg_transfer = 0;
        tick(1);
    endtask
    // bounded wait for the finished flag, c counts cycles spent
    task automatic wait_fin();
        c = 0;
        while (axis_attribute_byte[ATTR_FINISHED] !== 1'b1) begin
            tick(1);
            c++;
            if (c > 500) begin
                n_mismatch++;
                give_verdict();
            end
        end
    endtask
    // main sequence: reset, table of non-moving jobs, then awkward cases
    initial begin
        tick(5);
        rst = 0;
        tick(1);
        chk("attr_reset", axis_attribute_byte, 8'he9);
        chk("ready_reset", operational_ready_output, 1'b0);
        job(MODE_REL_MOVE, 32'ha);
        chk("no_cfg_err", job_error, ERR_REJECTED);
        tick(1);
        cfg(1'b1);
        chk("cfg_miss", axis_attribute_byte[ATTR_CFG_MISS], 1'b0);
        chk("unit", axis_attribute_byte[1:0], UNIT_INCH);
        chk("ready_bad", operational_ready_output, 1'b0);
        job(MODE_REL_MOVE, 32'ha);
        chk("bad_cfg_err", job_error, ERR_REJECTED);
        chk("no_motion", motion_enable, 1'b0);
        tick(1);
        cfg(1'b0);
        chk("ready_ok", operational_ready_output, 1'b1);
        cpu_ready = 0;
        tick(1);
        chk("ready_cpu", operational_ready_output, 1'b0);
        cpu_ready = 1;
        job(MODE_ABS_MOVE, 32'h64);
        chk("abs_noref", job_error, ERR_REJECTED);
        tick(1);
        // non-moving jobs still pass through running; issued only when finished
        foreach (rows[i]) begin
            job(rows[i].m, 32'h0);
            chk("accept", job_accept, 1'b1);
            chk("running", axis_attribute_byte[ATTR_FINISHED], 1'b0);
            wait_fin();
            chk("teach", axis_attribute_byte[ATTR_TEACH], rows[i].teach);
        end
        job(MODE_REF_APPROACH, 32'h0);
        ref_set = 1;
        tick(1);
        ref_set = 0;
        wait_fin();
        chk("ref_miss", axis_attribute_byte[ATTR_REF_MISS], 1'b0);
        job(MODE_ABS_MOVE, 32'h64);
        chk("ctrl_on", axis_attribute_byte[ATTR_CTRL_ON], 1'b1);
        chk("moving", motion_enable, 1'b1);
        wait_fin();
        chk("reached", axis_attribute_byte[ATTR_IN_POS], 1'b1);
        chk("pin_out", in_position_output, 1'b1);
        chk("target", target_pos, 32'h64);
        // second request while running must be refused
        job(MODE_REL_MOVE, 32'h32);
        tick(1);
        job(MODE_ABS_MOVE, 32'h0);
        chk("busy", job_error, ERR_REJECTED);
        wait_fin();
        // load holds actual away from target: wait timer ends the job
        stall = 1;
        job(MODE_ABS_MOVE, 32'h12c);
        wait_fin();
        // 36 ramp cycles at step 7 from 0x32 to 0x12c, then the 50-cycle wait count
        chk("wait_len", c, 32'd86);
        chk("timeout_err", job_error, ERR_NOT_REACHED);
        chk("timeout_pr", axis_attribute_byte[ATTR_IN_POS], 1'b0);
        stall = 0;
        tick(3);
        job(MODE_ABS_MOVE, 32'h3e8);
        tick(10);
        job_abort = 1;
        tick(1);
        job_abort = 0;
        wait_fin();
        tick(3);
        chk("abort_pr", axis_attribute_byte[ATTR_IN_POS], 1'b0);
        chk("dist", distance_to_go, 32'h3e8 - setpoint);
        // jog stop: target follows frozen actual plus braking distance
        job(MODE_JOG_ONE, 32'h0);
        tick(5);
        stall = 1;
        job_stop = 1;
        tick(3);
        chk("jog_tgt", target_pos, actual + 32'h14);
        job_stop = 0;
        stall = 0;
        wait_fin();
        chk("jog_pr", axis_attribute_byte[ATTR_IN_POS], 1'b1);
        job(MODE_JOG_OPEN, 32'h0);
        tick(2);
        chk("open_loop", axis_attribute_byte[ATTR_CTRL_ON], 1'b0);
        job_stop = 1;
        tick(1);
        job_stop = 0;
        wait_fin();
        chk("open_pr", axis_attribute_byte[ATTR_IN_POS], 1'b1);
        job(MODE_AUTO, 32'h0);
        tick(3);
        stmt_done = 1;
        tick(1);
        stmt_done = 0;
        tick(2);
        chk("auto_pr", axis_attribute_byte[ATTR_IN_POS], 1'b1);
        chk("auto_run", axis_attribute_byte[ATTR_FINISHED], 1'b0);
        program_done = 1;
        tick(1);
        program_done = 0;
        wait_fin();
        // reset in mid-job returns the byte to its power-up value
        job(MODE_REL_MOVE, 32'h0);
        rst = 1;
        tick(2);
        rst = 0;
        tick(1);
        chk("attr_rerun", axis_attribute_byte, 8'he9);
        chk("ready_rerun", operational_ready_output, 1'b0);
        chk("err_rerun", job_error, ERR_NONE);
        give_verdict();
    end
endmodule

// ---- logic/asr_axis_status.sv ----
// per-axis attribute byte, job status and position-reached logic
// Overview of operation
// RULE1: bit3 high while position controller active
// RULE2: bit4 reports teach-in active
// RULE3: bit5 high until reference point established
// RULE4: bit6 high while configuration data absent
// RULE5: configuration transfer clears bit6 despite errors
// RULE6: moves executed only with error-free configuration
// RULE7: absolute moves need reference; reference clears bit5
// RULE8: teach on/off modes drive teach flag
// RULE9: controller off only in open-loop, following-error
// RULE10: mode changes accepted only when finished
// RULE11: every accepted job sets status running
// RULE12: automatic program stays running until complete
// RULE13: reached when setpoint at target, actual in window
// RULE14: non-automatic reached sets finished same step
// RULE15: automatic: reached per statement, status stays running
// RULE16: jog stop: target is actual plus braking
// RULE17: open-loop jog: standstill sets finished and reached
// RULE18: abort leaves reached clear, distance keeps updating; an aborted automatic job keeps reached if a statement set it
// RULE19: setpoint at target, actual outside: start wait
// RULE20: wait expiry: not-reached error, finished, reached clear
// RULE21: open-loop jog drifting after stop uses timer
// RULE22: ready and reached outputs active high
// RULE23: bit2 in-position, bit7 finished, bits0-1 unit
`timescale 1ns/1ns
module asr_axis_status
    import asr_pkg::*;
#(
    parameter int POS_W = 32,
    parameter longint WAIT_COUNT = WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan_tick,
    input wire logic job_valid,
    input wire logic [3:0] job_mode,
    input wire logic job_stop,
    input wire logic job_abort,
    input wire logic [POS_W-1:0] job_target,
    input wire logic cfg_transfer,
    input wire logic cfg_error,
    input wire logic [1:0] cfg_unit,
    input wire logic ref_set,
    input wire logic cpu_ready,
    input wire logic stmt_done,
    input wire logic program_done,
    input wire logic [POS_W-1:0] setpoint,
    input wire logic [POS_W-1:0] actual,
    input wire logic [POS_W-1:0] brake_dist,
    input wire logic [POS_W-1:0] standstill_window,
    output logic [7:0] axis_attribute_byte,
    output logic job_accept,
    output logic [1:0] job_error,
    output logic motion_enable,
    output logic [POS_W-1:0] target_pos,
    output logic [POS_W-1:0] distance_to_go,
    output logic operational_ready_output,
    output logic in_position_output
);
    localparam int WAIT_W = $clog2(WAIT_COUNT + 1);

    typedef struct packed {
        asr_state_t state;
        logic [3:0] mode;
        logic [1:0] unit;
        logic ctrl_on;
        logic teach;
        logic ref_miss;
        logic cfg_miss;
        logic cfg_bad;
        logic finished;
        logic reached;
        logic accept;
        logic [1:0] err;
        logic [POS_W-1:0] target;
        logic [POS_W-1:0] dtg;
        logic dtg_live;
        logic [POS_W-1:0] last_actual;
        logic [POS_W-1:0] last_dist;
        logic [WAIT_W-1:0] wait_cnt;
        logic waiting;
    } asr_reg_t;

    asr_reg_t r;
    asr_reg_t next_r;

    // absolute distance between two positions, used for window and approach tests
    function automatic logic [POS_W-1:0] asr_abs_diff(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
        logic signed [POS_W-1:0] d;
        d = $signed(a) - $signed(b);
        return d[POS_W-1] ? POS_W'(-d) : POS_W'(d);
    endfunction

    logic is_motion;
    logic setpoint_at;
    logic in_window;
    logic mode_ok;
    logic [POS_W-1:0] cur_dist;

    // job classification and position tests
    always_comb begin
        is_motion = (job_mode == MODE_JOG_ONE) || (job_mode == MODE_JOG_TWO) || (job_mode == MODE_JOG_OPEN)
            || (job_mode == MODE_ABS_MOVE) || (job_mode == MODE_REL_MOVE) || (job_mode == MODE_REF_APPROACH)
            || (job_mode == MODE_AUTO);
        mode_ok = !(is_motion && r.cfg_bad) && !((job_mode == MODE_ABS_MOVE) && r.ref_miss); // RULE6 RULE7
        setpoint_at = (setpoint == r.target);
        cur_dist = asr_abs_diff(actual, r.target);
        in_window = (cur_dist <= standstill_window);
    end

    // next-state logic for the whole axis
    always_comb begin
        next_r = r;
        next_r.accept = 1'b0;
        if (cfg_transfer) begin
            next_r.cfg_miss = 1'b0; // RULE5 RULE4
            next_r.cfg_bad = cfg_error;
            next_r.unit = cfg_unit;
        end
        if (r.dtg_live) begin
            // signed remaining path from setpoint to the last accepted job's target
            next_r.dtg = r.target - setpoint; // RULE18
        end
        case (r.state)
            ASR_IDLE: begin
                // only a finished axis takes a new job; others are dropped
                if (job_valid && r.finished) begin // RULE10
                    if (mode_ok) begin
                        next_r.accept = 1'b1;
                        next_r.err = ERR_NONE;
                        next_r.mode = job_mode;
                        next_r.finished = 1'b0; // RULE11
                        next_r.reached = 1'b0;
                        next_r.waiting = 1'b0;
                        next_r.wait_cnt = '0;
                        // only a new traversing job ends distance-to-go tracking;
                        // following-error, teach and other non-moving jobs keep it live after an abort
                        if (is_motion) begin
                            next_r.dtg_live = 1'b0; // RULE18
                        end
                        next_r.ctrl_on = !((job_mode == MODE_JOG_OPEN) || (job_mode == MODE_FOLLOW_ERR)); // RULE9
                        next_r.target = job_target;
                        next_r.last_dist = asr_abs_diff(actual, job_target);
                        next_r.state = ASR_RUN;
                    end else begin
                        next_r.err = ERR_REJECTED;
                    end
                end
            end
            ASR_RUN: begin
                if (job_abort) begin
                    next_r.finished = 1'b1;
                    next_r.dtg_live = 1'b1; // RULE18
                    next_r.ctrl_on = 1'b1;
                    next_r.state = ASR_IDLE;
                end else begin
                    case (r.mode)
                        MODE_TEACH_ON, MODE_TEACH_OFF: begin
                            next_r.teach = (r.mode == MODE_TEACH_ON); // RULE8 RULE2
                            next_r.finished = 1'b1;
                            next_r.state = ASR_IDLE;
                        end
                        MODE_REF_APPROACH: begin
                            if (ref_set) begin
                                next_r.ref_miss = 1'b0; // RULE7 RULE3
                                next_r.finished = 1'b1;
                                next_r.state = ASR_IDLE;
                            end
                        end
                        MODE_JOG_ONE, MODE_JOG_TWO, MODE_JOG_OPEN: begin
                            if (job_stop) begin
                                next_r.target = actual + brake_dist; // RULE16
                                next_r.last_actual = actual;
                                next_r.last_dist = brake_dist;
                                next_r.state = ASR_STOPPING;
                            end
                        end
                        MODE_ABS_MOVE, MODE_REL_MOVE: begin
                            next_r.state = ASR_STOPPING;
                        end
                        MODE_AUTO: begin
                            if (stmt_done) begin
                                next_r.reached = 1'b1; // RULE15
                            end else if (job_valid) begin
                                next_r.reached = 1'b0;
                            end
                            if (program_done) begin
                                next_r.finished = 1'b1; // RULE12
                                next_r.state = ASR_IDLE;
                            end
                        end
                        default: begin
                            // non-moving job: one step of running, then finished
                            next_r.finished = 1'b1;
                            next_r.ctrl_on = 1'b1;
                            next_r.state = ASR_IDLE;
                        end
                    endcase
                end
            end
            ASR_STOPPING: begin
                if (job_abort) begin
                    next_r.finished = 1'b1;
                    next_r.dtg_live = 1'b1; // RULE18
                    next_r.ctrl_on = 1'b1;
                    next_r.state = ASR_IDLE;
                end else if (r.mode == MODE_JOG_OPEN && scan_tick && actual == r.last_actual) begin
                    next_r.finished = 1'b1; // RULE17
                    next_r.reached = 1'b1;
                    next_r.ctrl_on = 1'b1;
                    next_r.state = ASR_IDLE;
                end else if (r.mode != MODE_JOG_OPEN && setpoint_at && in_window) begin
                    next_r.reached = 1'b1; // RULE13
                    next_r.finished = 1'b1; // RULE14
                    next_r.state = ASR_IDLE;
                end else if (r.waiting && r.wait_cnt == WAIT_W'(WAIT_COUNT - 1)) begin
                    next_r.err = ERR_NOT_REACHED; // RULE20
                    next_r.finished = 1'b1;
                    next_r.reached = 1'b0;
                    next_r.waiting = 1'b0;
                    next_r.ctrl_on = 1'b1;
                    next_r.state = ASR_IDLE;
                end else begin
                    if (scan_tick) begin
                        next_r.last_actual = actual;
                    end
                    // setpoint settled but axis outside window: watchdog runs
                    if (setpoint_at || r.mode == MODE_JOG_OPEN) begin // RULE19 RULE21
                        next_r.waiting = 1'b1;
                        if (cur_dist < r.last_dist) begin
                            next_r.wait_cnt = '0; // RULE20
                        end else begin
                            next_r.wait_cnt = r.wait_cnt + WAIT_W'(1);
                        end
                    end
                    next_r.last_dist = cur_dist;
                end
            end
            default: begin
                next_r.state = ASR_IDLE;
            end
        endcase
        if (job_valid && (r.state != ASR_IDLE) && r.mode != MODE_AUTO) begin
            next_r.err = ERR_REJECTED; // RULE10
        end
    end

    // single register stage for all axis state
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.state <= ASR_IDLE;
            r.unit <= UNIT_RESET;
            r.ctrl_on <= 1'b1;
            r.ref_miss <= 1'b1;
            r.cfg_miss <= 1'b1;
            r.cfg_bad <= 1'b1;
            r.finished <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // attribute byte and pins
    always_comb begin
        axis_attribute_byte = '0;
        axis_attribute_byte[ATTR_UNIT_HI:ATTR_UNIT_LO] = r.unit; // RULE23
        axis_attribute_byte[ATTR_IN_POS] = r.reached;
        axis_attribute_byte[ATTR_CTRL_ON] = r.ctrl_on; // RULE1
        axis_attribute_byte[ATTR_TEACH] = r.teach; // RULE2
        axis_attribute_byte[ATTR_REF_MISS] = r.ref_miss; // RULE3
        axis_attribute_byte[ATTR_CFG_MISS] = r.cfg_miss; // RULE4
        axis_attribute_byte[ATTR_FINISHED] = r.finished;
    end
    assign job_accept = r.accept;
    assign job_error = r.err;
    assign motion_enable = (r.state != ASR_IDLE) && !r.cfg_bad; // RULE6
    assign target_pos = r.target;
    assign distance_to_go = r.dtg;
    // ready waits for valid configuration, so a drive is never enabled blind
    assign operational_ready_output = cpu_ready && !r.cfg_miss && !r.cfg_bad; // RULE22
    assign in_position_output = r.reached; // RULE22

    property p_reached_finish;
        @(posedge clk) disable iff (rst)
        (r.state == ASR_STOPPING && r.mode != MODE_JOG_OPEN && !job_abort && setpoint_at && in_window)
        |=> (in_position_output && axis_attribute_byte[ATTR_FINISHED]);
    endproperty
    a_reached_finish: assert property (p_reached_finish) else $error("reached did not finish job"); // RULE13
    property p_no_accept_running;
        @(posedge clk) disable iff (rst)
        (job_valid && !axis_attribute_byte[ATTR_FINISHED]) |=> !job_accept;
    endproperty
    a_no_accept_running: assert property (p_no_accept_running) else $error("job accepted while running"); // RULE10
    property p_accept_running;
        @(posedge clk) disable iff (rst)
        job_accept |-> !axis_attribute_byte[ATTR_FINISHED];
    endproperty
    a_accept_running: assert property (p_accept_running) else $error("accepted job not running"); // RULE11
    property p_cfg_clear;
        @(posedge clk) disable iff (rst)
        cfg_transfer |=> !axis_attribute_byte[ATTR_CFG_MISS];
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("config flag not cleared"); // RULE5
    property p_open_loop;
        @(posedge clk) disable iff (rst)
        (job_accept && r.mode == MODE_JOG_OPEN) |-> !axis_attribute_byte[ATTR_CTRL_ON];
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop controller on"); // RULE9
    property p_auto_running;
        @(posedge clk) disable iff (rst)
        (r.state == ASR_RUN && r.mode == MODE_AUTO && !program_done && !job_abort) |=> !axis_attribute_byte[ATTR_FINISHED];
    endproperty
    a_auto_running: assert property (p_auto_running) else $error("auto finished early"); // RULE12
    property p_pin_mirror;
        @(posedge clk) disable iff (rst)
        in_position_output == axis_attribute_byte[ATTR_IN_POS];
    endproperty
    a_pin_mirror: assert property (p_pin_mirror) else $error("reached pin mismatch"); // RULE22
    property p_timeout;
        @(posedge clk) disable iff (rst)
        (job_error != ERR_NOT_REACHED) ##1 (job_error == ERR_NOT_REACHED) |-> !in_position_output && axis_attribute_byte[ATTR_FINISHED];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout state wrong"); // RULE20
    property p_teach;
        @(posedge clk) disable iff (rst)
        (r.state == ASR_RUN && r.mode == MODE_TEACH_ON && !job_abort) |=> axis_attribute_byte[ATTR_TEACH];
    endproperty
    a_teach: assert property (p_teach) else $error("teach flag not set"); // RULE8
    property p_abort_clear;
        @(posedge clk) disable iff (rst)
        (r.state != ASR_IDLE && r.mode != MODE_AUTO && job_abort) |=> (axis_attribute_byte[ATTR_FINISHED] && !in_position_output);
    endproperty
    a_abort_clear: assert property (p_abort_clear) else $error("abort left reached set"); // RULE18
    property p_ref_clear;
        @(posedge clk) disable iff (rst)
        (r.state == ASR_RUN && r.mode == MODE_REF_APPROACH && ref_set && !job_abort) |=> !axis_attribute_byte[ATTR_REF_MISS];
    endproperty
    a_ref_clear: assert property (p_ref_clear) else $error("reference flag not cleared"); // RULE7
    property p_bad_cfg_reject;
        @(posedge clk) disable iff (rst)
        (job_valid && r.cfg_bad && job_mode == MODE_REL_MOVE) |=> !job_accept;
    endproperty
    a_bad_cfg_reject: assert property (p_bad_cfg_reject) else $error("move accepted with bad config"); // RULE6
endmodule

// ---- logic/asr_pkg.sv ----
// shared constants and types for the axis status and position-reached block
package asr_pkg;
    // attribute byte bit positions
    localparam int ATTR_UNIT_LO = 0;
    localparam int ATTR_UNIT_HI = 1;
    localparam int ATTR_IN_POS = 2;
    localparam int ATTR_CTRL_ON = 3;
    localparam int ATTR_TEACH = 4;
    localparam int ATTR_REF_MISS = 5;
    localparam int ATTR_CFG_MISS = 6;
    localparam int ATTR_FINISHED = 7;
    // measurement unit codes
    localparam logic [1:0] UNIT_METRIC = 2'h1;
    localparam logic [1:0] UNIT_INCH = 2'h2;
    localparam logic [1:0] UNIT_DEGREE = 2'h0;
    // job mode codes
    localparam logic [3:0] MODE_JOG_ONE = 4'h1;
    localparam logic [3:0] MODE_JOG_TWO = 4'h2;
    localparam logic [3:0] MODE_JOG_OPEN = 4'h3;
    localparam logic [3:0] MODE_FOLLOW_ERR = 4'h4;
    localparam logic [3:0] MODE_REF_APPROACH = 4'h5;
    localparam logic [3:0] MODE_ABS_MOVE = 4'h6;
    localparam logic [3:0] MODE_REL_MOVE = 4'h7;
    localparam logic [3:0] MODE_AUTO = 4'h8;
    localparam logic [3:0] MODE_TEACH_ON = 4'ha;
    localparam logic [3:0] MODE_TEACH_OFF = 4'hb;
    localparam logic [3:0] MODE_OTHER = 4'hc;
    // error codes reported per job
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_REJECTED = 2'h1;
    localparam logic [1:0] ERR_NOT_REACHED = 2'h2;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int WAIT_TIME_MS = 5000;
    localparam longint WAIT_CYCLES = longint'(WAIT_TIME_MS) * 1000 * CLK_MHZ;
    // reset values
    localparam logic [1:0] UNIT_RESET = UNIT_METRIC;
    // job sequencer states
    typedef enum logic [2:0] {
        ASR_IDLE = 3'b001,
        ASR_RUN = 3'b010,
        ASR_STOPPING = 3'b100
    } asr_state_t;
endpackage
